// ==== hdl/acs_defines.svh ====
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

`define ACS_ADDR_W 12
`define ACS_OFF_RESULT 12'h000
`define ACS_OFF_CONFIG 12'h004
`define ACS_OFF_STATUS 12'h008
`define ACS_OFF_CTRL 12'h00C
`define ACS_CTRL_GCALL_BIT 0
`define ACS_CFG_RESET 16'h8580
`define ACS_GAIN_FIXED 3'h2
`define ACS_RST_HOLD 4'h8
`define ACS_RAW_MAX 16'h07FF
`define ACS_RAW_MIN 16'hF800
`define ACS_CODE_MAX 12'h7FF
`define ACS_CODE_MIN 12'h800
`define ACS_LSB_PAD 4'h0
`define ACS_SPS_LIST '{32'h80, 32'hFA, 32'h1EA, 32'h398, 32'h640, 32'h960, 32'hCE4, 32'hCE4}
`define ACS_FS_6144 16'h1800
`define ACS_FS_4096 16'h1000
`define ACS_FS_2048 16'h0800
`define ACS_FS_1024 16'h0400
`define ACS_FS_0512 16'h0200
`define ACS_FS_0256 16'h0100

`endif

// ==== hdl/acs_pkg.sv ====
`include "acs_defines.svh"
`default_nettype none
package acs_pkg;
	// configuration word as software sees it; start/status is the top bit
	typedef struct packed {
		logic start;
		logic [2:0] mux;
		logic [2:0] gain;
		logic single;
		logic [2:0] rate;
		logic [4:0] rsvd;
	} acs_cfg_type;

	typedef struct packed {
		logic [15:0] range_mv;
		logic [11:0] rsvd;
		logic gnd_sw;
		logic powered_down;
		logic new_result;
		logic busy;
	} acs_status_type;

	// routing towards the analog selector
	typedef struct packed {
		logic [1:0] pos;
		logic [1:0] neg;
		logic gnd_sw;
	} acs_route_type;

	typedef enum logic [1:0] {
		ANALOG_IN_FIRST = 2'b00,
		ANALOG_IN_SECOND = 2'b01,
		ANALOG_IN_THIRD = 2'b10,
		ANALOG_IN_FOURTH = 2'b11
	} acs_ain_type;

	typedef enum logic [0:0] {
		ST_DOWN = 1'b0,
		ST_BUSY = 1'b1
	} acs_state_type;

	localparam int unsigned ACS_SPS [0:7] = `ACS_SPS_LIST;

	// selector codes: 0..3 differential, 4..7 single-ended against ground
	function automatic acs_route_type acs_route(input logic [2:0] mux);
		acs_route_type r;
		r = '0;
		case (mux)
			3'h0: begin r.pos = ANALOG_IN_FIRST; r.neg = ANALOG_IN_SECOND; end
			3'h1: begin r.pos = ANALOG_IN_FIRST; r.neg = ANALOG_IN_FOURTH; end
			3'h2: begin r.pos = ANALOG_IN_SECOND; r.neg = ANALOG_IN_FOURTH; end
			3'h3: begin r.pos = ANALOG_IN_THIRD; r.neg = ANALOG_IN_FOURTH; end
			default: begin r.pos = mux[1:0]; r.gnd_sw = 1'b1; end
		endcase
		return r;
	endfunction

	// full range in millivolts for each gain code; codes 6 and 7 alias code 5 (256)
	function automatic logic [15:0] acs_range_mv(input logic [2:0] gain);
		case (gain)
			3'h0: return `ACS_FS_6144;
			3'h1: return `ACS_FS_4096;
			3'h2: return `ACS_FS_2048;
			3'h3: return `ACS_FS_1024;
			3'h4: return `ACS_FS_0512;
			default: return `ACS_FS_0256;
		endcase
	endfunction
endpackage
`default_nettype wire

// ==== hdl/acs_sync.sv ====
`default_nettype none
module acs_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta;

	// two-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta <= '0;
			q_out <= '0;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/acs_link.sv ====
`include "acs_defines.svh"
`default_nettype none
module acs_link
	import acs_pkg::*;
#(
	parameter int LINK_CLK_HZ = 166666666,
	parameter int CW = 24
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic [2:0] rate_in,
	input wire logic [15:0] raw_in,
	output logic done_out,
	output logic [15:0] result_out,
	output logic run_out
);
	logic req_seen;
	logic [CW-1:0] cnt;

	// length of one conversion in link cycles, never below one
	function automatic logic [CW-1:0] period(input logic [2:0] rate);
		int unsigned p;
		p = LINK_CLK_HZ / ACS_SPS[rate];
		if (p < 1)
			p = 1;
		return CW'(p - 1);
	endfunction

	// clip to the 12-bit range, then left-justify in 16 bits
	function automatic logic [15:0] fmt(input logic [15:0] raw);
		logic [11:0] code;
		code = raw[11:0];
		if ($signed(raw) > $signed(`ACS_RAW_MAX))
			code = `ACS_CODE_MAX;
		else if ($signed(raw) < $signed(`ACS_RAW_MIN))
			code = `ACS_CODE_MIN;
		return {code, `ACS_LSB_PAD};
	endfunction

	// conversion timer: a toggle starts one conversion of the programmed length
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			req_seen <= 1'b0;
			run_out <= 1'b0;
			cnt <= '0;
			done_out <= 1'b0;
			result_out <= '0;
		end else if (!run_out && req_in != req_seen) begin
			req_seen <= req_in;
			run_out <= 1'b1;
			cnt <= period(rate_in);
		end else if (run_out) begin
			if (cnt == '0) begin
				run_out <= 1'b0;
				result_out <= fmt(raw_in); // word is stable before the toggle is seen
				done_out <= ~done_out;
			end else begin
				cnt <= cnt - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hdl/acs_top.sv ====
`include "acs_defines.svh"
`default_nettype none
module acs_top
	import acs_pkg::*;
#(
	parameter int LINK_CLK_HZ = 166666666,
	parameter bit HAS_GAIN = 1'b1
) (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic LINK_CLK_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [`ACS_ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [15:0] RAW_CODE_IN,
	output logic PREADY_OUT,
	output logic [31:0] PRDATA_OUT,
	output logic PSLVERR_OUT,
	output logic [1:0] POS_SEL_OUT,
	output logic [1:0] NEG_SEL_OUT,
	output logic GND_SW_OUT,
	output logic [2:0] GAIN_SEL_OUT,
	output logic POWER_DOWN_OUT,
	output logic MOD_RUN_OUT
);
	// bus decode
	logic setup;
	logic apb_wr;
	logic cfg_wr;
	logic ctrl_wr;
	logic rd_result;
	logic [31:0] rd_word;
	logic rd_err;
	acs_cfg_type wcfg;

	// reset control
	logic gc_pulse;
	logic soft_rst;
	logic [3:0] rst_cnt;
	logic rst_hold;
	logic link_rst;

	// configuration and sequencing
	acs_cfg_type cfg;
	acs_state_type state;
	acs_state_type next_state;
	logic launch;
	logic relaunch;
	logic finish;
	logic start_flag;
	logic start_wr;
	logic req_tgl;
	logic [2:0] req_rate;
	logic [15:0] result;
	logic new_result;
	logic [2:0] gain_eff;
	acs_route_type route;

	// crossings
	logic req_link;
	logic done_link;
	logic done_sync;
	logic done_seen;
	logic done_evt;
	logic [15:0] link_result;

	// status and configuration words as read back
	acs_status_type status;
	acs_cfg_type cfg_rd;

	// reset image of the configuration word
	localparam acs_cfg_type CFG_RST = acs_cfg_type'(`ACS_CFG_RESET);

	assign setup = PSEL_IN & ~PENABLE_IN;
	assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
	assign cfg_wr = apb_wr & (PADDR_IN == `ACS_OFF_CONFIG);
	assign ctrl_wr = apb_wr & (PADDR_IN == `ACS_OFF_CTRL);
	assign rd_result = setup & ~PWRITE_IN & (PADDR_IN == `ACS_OFF_RESULT);
	assign wcfg = acs_cfg_type'(PWDATA_IN[15:0]);

	// a general call reset behaves like a power-up reset for everything but the bus and the registered output drives
	assign soft_rst = RST_IN | gc_pulse;

	// start only counts in single-shot mode; the mode written in the same word decides
	assign start_wr = cfg_wr & wcfg.start & wcfg.single;

	// a fixed-range part uses the gain field only in the configuration read-back
	assign gain_eff = HAS_GAIN ? cfg.gain : `ACS_GAIN_FIXED;
	assign route = acs_route(cfg.mux);

	assign done_evt = done_sync != done_seen;

	// configuration read-back; start/status comes from the sequencer, reserved bits read zero
	always_comb begin
		cfg_rd = cfg;
		cfg_rd.start = start_flag;
		cfg_rd.rsvd = '0;
	end

	// status word as software sees it
	always_comb begin
		status = '0;
		status.range_mv = acs_range_mv(gain_eff);
		status.gnd_sw = route.gnd_sw;
		status.powered_down = (state == ST_DOWN);
		status.new_result = new_result;
		status.busy = (state == ST_BUSY);
	end

	// read mux; unmapped or misaligned addresses answer with an error and zero data
	always_comb begin
		rd_word = '0;
		rd_err = 1'b0;
		case (PADDR_IN)
			`ACS_OFF_RESULT: rd_word = {16'h0000, result};
			`ACS_OFF_CONFIG: rd_word = {16'h0000, cfg_rd};
			`ACS_OFF_STATUS: rd_word = status;
			`ACS_OFF_CTRL: rd_word = '0;
			default: rd_err = 1'b1;
		endcase
	end

	// zero-wait slave: answer is prepared in the setup cycle, ready in the first access cycle
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT <= setup;
			PSLVERR_OUT <= setup & rd_err;
		end
	end

	// read data is taken once at setup; writes read back zero
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			PRDATA_OUT <= '0;
		else if (setup & ~PWRITE_IN)
			PRDATA_OUT <= rd_word; // sampled once, so a word never mixes two results
		else if (setup)
			PRDATA_OUT <= '0;
	end

	// general call reset pulse, one cycle after the control write
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			gc_pulse <= 1'b0;
		else
			gc_pulse <= ctrl_wr & PWDATA_IN[`ACS_CTRL_GCALL_BIT];
	end

	// stretch any reset so the faster link domain surely sees it
	always_ff @(posedge CLOCK_IN) begin
		if (soft_rst)
			rst_cnt <= `ACS_RST_HOLD;
		else if (rst_cnt != '0)
			rst_cnt <= rst_cnt - 1'b1;
	end

	// hold flag stays up until the stretch counter has run out
	always_ff @(posedge CLOCK_IN) begin
		if (soft_rst)
			rst_hold <= 1'b1;
		else
			rst_hold <= (rst_cnt != '0);
	end

	// software configuration fields
	always_ff @(posedge CLOCK_IN) begin
		if (soft_rst) begin
			cfg <= acs_cfg_type'(`ACS_CFG_RESET);
		end else if (cfg_wr) begin
			cfg <= wcfg;
		end
	end

	// sequencing events; only the state decides, so a start write while busy has no effect
	always_comb begin
		next_state = state;
		launch = 1'b0;
		relaunch = 1'b0;
		finish = 1'b0;
		case (state)
			ST_DOWN: begin
				// held off while the link side is still coming out of reset
				if (!rst_hold && (!cfg.single || start_wr)) begin
					next_state = ST_BUSY;
					launch = 1'b1;
				end
			end
			ST_BUSY: begin
				// start writes land here and are dropped
				if (done_evt) begin
					if (!cfg.single) begin
						relaunch = 1'b1;
					end else begin
						next_state = ST_DOWN;
						finish = 1'b1;
					end
				end
			end
			default: begin
				next_state = ST_DOWN;
			end
		endcase
	end

	// conversion sequencer state
	always_ff @(posedge CLOCK_IN) begin
		if (soft_rst)
			state <= ST_DOWN;
		else
			state <= next_state;
	end

	// start/status bit reads low while a conversion runs, high once a single-shot result is stored
	always_ff @(posedge CLOCK_IN) begin
		if (soft_rst)
			start_flag <= 1'b1;
		else if (launch)
			start_flag <= 1'b0;
		else if (finish)
			start_flag <= 1'b1;
	end

	// one toggle per conversion request; a pulse could be missed by the other clock
	always_ff @(posedge CLOCK_IN) begin
		if (soft_rst)
			req_tgl <= 1'b0;
		else if (launch || relaunch)
			req_tgl <= ~req_tgl;
	end

	// rate word moves only with the toggle, so it has settled before the link samples it
	always_ff @(posedge CLOCK_IN) begin
		if (soft_rst)
			req_rate <= CFG_RST.rate;
		else if (launch && start_wr)
			req_rate <= wcfg.rate;
		else if (launch || relaunch)
			req_rate <= cfg.rate;
	end

	// done toggle edge tracking; stale edges from a link reset are absorbed when idle
	always_ff @(posedge CLOCK_IN) begin
		if (soft_rst)
			done_seen <= 1'b0;
		else
			done_seen <= done_sync;
	end

	// result register changes only on a completed conversion, all 16 bits together
	always_ff @(posedge CLOCK_IN) begin
		if (soft_rst)
			result <= '0;
		else if (done_evt && state == ST_BUSY)
			result <= link_result;
	end

	// sticky fresh-result flag: a new result wins over the clear by a read
	always_ff @(posedge CLOCK_IN) begin
		if (soft_rst)
			new_result <= 1'b0;
		else if (done_evt && state == ST_BUSY)
			new_result <= 1'b1;
		else if (rd_result)
			new_result <= 1'b0;
	end

	// selector drive, registered so the analog switches change cleanly
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			POS_SEL_OUT <= '0;
			NEG_SEL_OUT <= '0;
		end else begin
			POS_SEL_OUT <= route.pos;
			NEG_SEL_OUT <= route.neg;
		end
	end

	// negative input grounded for single-ended selections
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			GND_SW_OUT <= 1'b0;
		else
			GND_SW_OUT <= route.gnd_sw;
	end

	// effective gain code; a fixed-range part always shows the middle range
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			GAIN_SEL_OUT <= `ACS_GAIN_FIXED;
		else
			GAIN_SEL_OUT <= gain_eff;
	end

	// power-down follows the sequencer state one cycle late
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN)
			POWER_DOWN_OUT <= 1'b1;
		else
			POWER_DOWN_OUT <= (state == ST_DOWN);
	end

	// link-domain reset, derived from the stretched system reset
	acs_sync #(.W(1)) u_rst_sync (
		.clk_in(LINK_CLK_IN),
		.rst_in(1'b0),
		.d_in(rst_hold),
		.q_out(link_rst)
	);

	// request toggle into the link domain; the rate word is held until completion
	acs_sync #(.W(1)) u_req_sync (
		.clk_in(LINK_CLK_IN),
		.rst_in(link_rst),
		.d_in(req_tgl),
		.q_out(req_link)
	);

	// completion toggle back; its result word is already stable when it arrives
	acs_sync #(.W(1)) u_done_sync (
		.clk_in(CLOCK_IN),
		.rst_in(soft_rst),
		.d_in(done_link),
		.q_out(done_sync)
	);

	// conversion timing and result formatting on the link clock
	acs_link #(
		.LINK_CLK_HZ(LINK_CLK_HZ),
		.CW(24)
	) u_link (
		.clk_in(LINK_CLK_IN),
		.rst_in(link_rst),
		.req_in(req_link),
		.rate_in(req_rate),
		.raw_in(RAW_CODE_IN),
		.done_out(done_link),
		.result_out(link_result),
		.run_out(MOD_RUN_OUT)
	);
endmodule
`default_nettype wire

// ==== sim/acs_monitor.sv ====
`default_nettype none
module acs_monitor #(
	parameter bit HAS_GAIN = 1'b1
) (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic PREADY_OUT,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic [1:0] POS_SEL_OUT,
	input wire logic [1:0] NEG_SEL_OUT,
	input wire logic GND_SW_OUT,
	input wire logic [2:0] GAIN_SEL_OUT,
	input wire logic POWER_DOWN_OUT
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);
	// address is held through the access phase, so one decode serves both phases
	wire logic mapped = PADDR_IN[1:0] == 2'h0 && PADDR_IN[11:4] == 8'h00;
	sequence s_setup;
		PSEL_IN && !PENABLE_IN;
	endsequence
	sequence s_cfg_wr;
		PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == 12'h004;
	endsequence
	sequence s_start;
		s_cfg_wr ##0 (PWDATA_IN[15] && PWDATA_IN[8] && POWER_DOWN_OUT);
	endsequence
	property p_ready;
		s_setup |=> PREADY_OUT;
	endproperty
	property p_ready_once;
		PREADY_OUT |=> !PREADY_OUT;
	endproperty
	property p_ready_qual;
		PREADY_OUT |-> PSEL_IN && PENABLE_IN;
	endproperty
	property p_err;
		PREADY_OUT |-> PSLVERR_OUT == !mapped;
	endproperty
	property p_fmt;
		PREADY_OUT && !PWRITE_IN && PADDR_IN == 12'h000
			|-> PRDATA_OUT[3:0] == 4'h0 && PRDATA_OUT[31:16] == 16'h0000;
	endproperty
	property p_route;
		s_cfg_wr |-> ##2 GND_SW_OUT == $past(PWDATA_IN[14], 2) && (GND_SW_OUT ?
			POS_SEL_OUT == $past(PWDATA_IN[13:12], 2) : POS_SEL_OUT < NEG_SEL_OUT);
	endproperty
	property p_gain;
		s_cfg_wr |-> ##2 GAIN_SEL_OUT == (HAS_GAIN ? $past(PWDATA_IN[11:9], 2) : 3'h2);
	endproperty
	property p_start;
		s_start |-> ##[1:3] !POWER_DOWN_OUT;
	endproperty
	a_ready: assert property (p_ready) else $error("ready missing after setup");
	a_ready_once: assert property (p_ready_once) else $error("ready held too long");
	a_ready_qual: assert property (p_ready_qual) else $error("ready outside access");
	a_err: assert property (p_err) else $error("error flag wrong for address");
	a_fmt: assert property (p_fmt) else $error("result padding not zero");
	a_route: assert property (p_route) else $error("selector routing wrong");
	a_gain: assert property (p_gain) else $error("gain code wrong");
	a_start: assert property (p_start) else $error("start did not wake");
endmodule
bind acs_top acs_monitor #(.HAS_GAIN(HAS_GAIN)) u_mon (.CLOCK_IN, .RST_IN, .PSEL_IN,
	.PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PREADY_OUT, .PRDATA_OUT, .PSLVERR_OUT,
	.POS_SEL_OUT, .NEG_SEL_OUT, .GND_SW_OUT, .GAIN_SEL_OUT, .POWER_DOWN_OUT);
`default_nettype wire

// ==== sim/acs_front.sv ====
`default_nettype none
module acs_front (
	input wire logic link_clk_in,
	input wire logic run_in,
	input wire logic [15:0] code_in,
	output logic [15:0] raw_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial raw_out = 16'h5A5A;
	// filter output means nothing outside a conversion, so it churns there
	always @(posedge link_clk_in) begin
		raw_out <= run_in ? code_in : ~raw_out;
	end
endmodule
`default_nettype wire

// ==== sim/tb_adc_conversion_sequencer.sv ====
`default_nettype none
module tb_adc_conversion_sequencer;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, lclk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rdy, err, gnd, pd, run, serr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdata, cfg;
	logic [15:0] code = '0, raw;
	logic [1:0] pos, neg;
	logic [2:0] gain, gain_fx;
	int n_mismatch = 0, checked = 0;
	int rlen = 0, rlen_last = 0;
	// codes past both limits and one step either side of zero
	logic [15:0] raws [8] = '{16'h0800, 16'hF7FF, 16'hFFFF, 16'h0001, 16'h0000, 16'h07FF,
		16'h7FFF, 16'h8000};
	logic [15:0] res [8] = '{16'h7FF0, 16'h8000, 16'hFFF0, 16'h0010, 16'h0000, 16'h7FF0,
		16'h7FF0, 16'h8000};
	logic [15:0] rng [8] = '{16'h1800, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100,
		16'h0100, 16'h0100};
	always #5 clk = ~clk;
	// odd offset keeps the link edges wandering against the system clock
	initial begin
		#1.7;
		forever #3 lclk = ~lclk;
	end
	acs_top #(.LINK_CLK_HZ(64000)) u_dut (.CLOCK_IN(clk), .RST_IN(rst), .LINK_CLK_IN(lclk),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.RAW_CODE_IN(raw), .PREADY_OUT(rdy), .PRDATA_OUT(prdata), .PSLVERR_OUT(err),
		.POS_SEL_OUT(pos), .NEG_SEL_OUT(neg), .GND_SW_OUT(gnd), .GAIN_SEL_OUT(gain),
		.POWER_DOWN_OUT(pd), .MOD_RUN_OUT(run));
	acs_front u_front (.link_clk_in(lclk), .run_in(run), .code_in(code), .raw_out(raw));
	// fixed-range variant on the same bus; only its gain drive is compared
	acs_top #(.LINK_CLK_HZ(64000), .HAS_GAIN(1'b0)) u_fixed (.CLOCK_IN(clk), .RST_IN(rst),
		.LINK_CLK_IN(lclk), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .RAW_CODE_IN(raw), .PREADY_OUT(), .PRDATA_OUT(), .PSLVERR_OUT(),
		.POS_SEL_OUT(), .NEG_SEL_OUT(), .GND_SW_OUT(), .GAIN_SEL_OUT(gain_fx),
		.POWER_DOWN_OUT(), .MOD_RUN_OUT());
	// link cycles of the last conversion, taken when the run flag drops
	always @(posedge lclk) begin
		rlen <= run ? rlen + 1 : 0;
		if (!run && rlen != 0) rlen_last <= rlen;
	end
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	// request held until ready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pen <= 1'h0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 16);
		if (n >= 16) n_mismatch++;
		rdata = prdata;
		serr = err;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp, input string name);
		apb(1'h0, a, 32'h0);
		chk(name, exp, rdata);
	endtask
	// polls status until a fresh result is flagged
	task wait_new;
		int n;
		n = 0;
		do begin
			apb(1'h0, 12'h008, 32'h0);
			n++;
		end while (rdata[1] !== 1'b1 && n < 300);
		if (n >= 300) n_mismatch++;
	endtask
	task final_report;
		if (n_mismatch == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#60us;
		n_mismatch++;
		final_report;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(12'h004, 32'h8580, "config");
		rd(12'h000, 32'h0, "result");
		apb(1'h0, 12'h010, 32'h0);
		chk("unmapped error", 32'h1, serr);
		repeat (12) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			cfg = 32'h8100 | (i << 12) | (i << 9) | (i << 5);
			code <= raws[i];
			apb(1'h1, 12'h004, cfg);
			rd(12'h004, cfg & 32'h7FFF, "start cleared");
			apb(1'h1, 12'h004, cfg);
			wait_new;
			chk("full range", rng[i], rdata[31:16]);
			chk("ground switch", i >= 4, gnd);
			chk("fixed gain", 32'h2, gain_fx);
			chk("run length", 32'hFA00 / acs_pkg::ACS_SPS[i], rlen_last);
			rd(12'h000, res[i], "result");
			rd(12'h004, cfg, "start set");
			rd(12'h008, {rng[i], 12'h000, i >= 4, 3'h4}, "status idle");
			chk("power down", 32'h1, pd);
		end
		code <= 16'h0100;
		apb(1'h1, 12'h004, 32'h02E0);
		wait_new;
		rd(12'h000, 32'h1000, "continuous first");
		code <= 16'h0200;
		wait_new;
		apb(1'h0, 12'h000, 32'h0);
		wait_new;
		rd(12'h000, 32'h2000, "continuous next");
		apb(1'h0, 12'h008, 32'h0);
		chk("busy", 32'h1, rdata[0]);
		chk("awake", 32'h0, pd);
		apb(1'h1, 12'h00C, 32'h1);
		repeat (4) @(posedge clk);
		rd(12'h004, 32'h8580, "config after general call");
		rd(12'h000, 32'h0, "result after general call");
		final_report;
	end
endmodule
`default_nettype wire
